//--- hw/lbs_channel.sv
// one led output: sequence state, breath counter, duty ramp and pwm pin
`timescale 1ns/1ps
module lbs_channel
  import lbs_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       tick_in,
  input  wire logic [3:0] pwm_in,
  input  wire logic [1:0] sel_in,
  input  wire logic       linked_in,
  input  wire logic       is_input_in,
  input  wire logic       pol_in,
  input  wire logic       drive_in,
  input  wire logic       press_in,
  input  wire logic [6:0] period_in,
  input  wire logic [2:0] count_in,
  input  wire logic [7:0] duty_in,
  input  wire logic [7:0] duty_dr_in,
  output logic            pin_out,
  output logic            oe_out,
  output logic            busy_out
);
  lbs_state_e state_reg;
  lbs_state_e state_next;
  logic       press_reg;
  logic [6:0] step_reg;
  logic [4:0] phase_reg;
  logic [2:0] left_reg;
  // ****************************************
  // decode of the selector
  // ****************************************
  // unlinked pulse falls back to direct drive
  wire       direct  = (sel_in == SEL_DIRECT) || (!linked_in && sel_in == SEL_PULSE1);
  wire       run     = !is_input_in && !direct;
  wire       rise    = press_in && !press_reg;
  wire       hold_rq = linked_in ? (press_in && sel_in != SEL_PULSE1) : drive_in;
  wire       brst_go = linked_in && sel_in == SEL_PULSE1 && rise;
  wire       pend    = linked_in && sel_in == SEL_HOLD;
  wire [6:0] per_m1  = (period_in == 7'h00) ? 7'h00 : period_in - 7'h01;
  wire       st_end  = tick_in && step_reg == per_m1;
  wire       br_end  = st_end && phase_reg == PHASE_LAST;
  // ****************************************
  // duty ramp, half period up, half down
  // ****************************************
  wire [3:0] ramp  = phase_reg[4] ? ~phase_reg[3:0] : phase_reg[3:0];
  wire [3:0] dmin  = direct ? duty_dr_in[3:0] : duty_in[3:0];
  wire [3:0] dmax  = direct ? duty_dr_in[7:4] : duty_in[7:4];
  wire [3:0] span  = (dmax > dmin) ? dmax - dmin : 4'h0;
  wire [7:0] prod  = span * ramp;
  wire [3:0] level = (ramp == 4'hF) ? dmax : dmin + prod[7:4];
  wire       d_on  = linked_in ? press_in : drive_in;
  wire       act   = is_input_in ? 1'b0 : (direct ? d_on : state_reg != ST_IDLE);
  // direct drive runs at the full pwm rate at the upper limit
  wire [3:0] code  = direct ? dmax : level;
  wire [4:0] dval  = (code == 4'h0) ? 5'h00 : {1'b0, code} + 5'h01;
  wire       on    = act && ({1'b0, pwm_in} < dval);
  // next state of the sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run && brst_go) state_next = ST_BURST;
        else if (run && hold_rq) state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (!run) state_next = ST_IDLE;
        else if (!hold_rq) state_next = pend ? ST_BURST : ST_IDLE;
      end
      ST_BURST: begin
        if (!run) state_next = ST_IDLE;
        else if (pend && press_in) state_next = ST_HOLD;
        else if (br_end && left_reg == 3'h0) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end
  // state, step and breath counters, all per channel
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      press_reg <= 1'b0;
      step_reg  <= 7'h00;
      phase_reg <= 5'h00;
      left_reg  <= 3'h0;
    end else begin
      state_reg <= state_next;
      press_reg <= press_in;
      step_reg  <= (state_reg == ST_IDLE || st_end) ? 7'h00 : step_reg + {6'h00, tick_in};
      phase_reg <= (state_reg == ST_IDLE) ? 5'h00 : phase_reg + {4'h0, st_end};
      if (state_reg != ST_BURST && state_next == ST_BURST) left_reg <= count_in;
      else if (state_reg == ST_BURST && br_end && left_reg != 3'h0) left_reg <= left_reg - 3'h1;
    end
  end
  // pin level follows polarity, enable drops for an input pin
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= 1'b1;
      oe_out  <= 1'b0;
    end else begin
      pin_out <= on ^ ~pol_in;
      oe_out  <= ~is_input_in;
    end
  end
  assign busy_out = state_reg != ST_IDLE;
endmodule

//--- hw/lbs_pkg.sv
// package: register map, reset values and timing of the led behaviour sequencer
package lbs_pkg;
  localparam int         NUM_LED       = 11;
  // register offsets
  localparam logic [7:0] OFS_BEH_LOW   = 8'h81;
  localparam logic [7:0] OFS_BEH_MID   = 8'h82;
  localparam logic [7:0] OFS_BEH_HIGH  = 8'h83;
  localparam logic [7:0] OFS_PULSE_ONE_PERIOD_FIELD    = 8'h84;
  localparam logic [7:0] OFS_PULSE_TWO_PERIOD_FIELD    = 8'h85;
  localparam logic [7:0] OFS_BREATHE_PERIOD_FIELD    = 8'h86;
  localparam logic [7:0] OFS_PULSE_CFG = 8'h88;
  localparam logic [7:0] OFS_DUTY_P1   = 8'h90;
  localparam logic [7:0] OFS_DUTY_P2   = 8'h91;
  localparam logic [7:0] OFS_DUTY_BR   = 8'h92;
  localparam logic [7:0] OFS_DUTY_DR   = 8'h93;
  // reset values
  localparam logic [7:0] RST_BEH       = 8'h00;
  localparam logic [6:0] RST_PULSE_ONE_PERIOD_FIELD    = 7'h20;
  localparam logic [6:0] RST_PULSE_TWO_PERIOD_FIELD    = 7'h14;
  localparam logic [6:0] RST_BREATHE_PERIOD_FIELD    = 7'h5D;
  localparam logic [5:0] RST_PULSE_CFG = 6'h24;
  localparam logic [7:0] RST_DUTY      = 8'hF0;
  // field positions
  localparam int         ALT_LSB       = 6;
  localparam int         AWAKE_LSB     = 4;
  localparam int         CNT1_LSB      = 0;
  localparam int         CNT2_LSB      = 3;
  // timing: one ms tick, each period lsb is 32 ms, so a breath is 32 steps
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         TICK_MS_NS    = 1000000;
  localparam int         TICK_CYCLES   = TICK_MS_NS / CLK_PERIOD_NS;
  localparam int         STEP_MS       = 32;
  localparam logic [4:0] PHASE_LAST    = 5'(STEP_MS - 1);
  typedef enum logic [1:0] {
    SEL_DIRECT  = 2'h0,
    SEL_PULSE1  = 2'h1,
    SEL_HOLD    = 2'h2,
    SEL_BREATHE = 2'h3
  } lbs_sel_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_HOLD  = 3'h2,
    ST_BURST = 3'h4
  } lbs_state_e;
endpackage

//--- hw/lbs_top.sv
// top of the led behaviour sequencer: registers, tick, selector routing
//
// Behaviour
// - Each led pin has its own two-bit selector, four behaviours each.
// - A pin set as input ignores its selector.
// - Linked outputs start on the start trigger and end on the stop trigger.
// - Unlinked outputs do direct or breathe only, driven by control bits.
// - Idle pin sits high under inverted polarity, low under non-inverted.
// - First register holds selectors of outputs four to one, high pair first.
// - Second register holds selectors of outputs eight to five likewise.
// - Output eleven uses bits 7:6 when power indicator set and asleep.
// - Output eleven uses bits 5:4 when power indicator set and awake.
// - Third register holds output ten in 3:2 and output nine in 1:0.
// - Selector 00 drives directly; linked, on press and off on release.
// - Selector 01 linked: press starts five breaths at pulse-one period.
// - Selector 10 linked: breathe while pressed, then five more breaths.
// - Selector 11 ramps duty up then down, each ramp half the period.
// - Pwm rate follows behaviour; direct with zero ramps runs full rate. Here all outputs share one 16-step pwm frame at one rate.
// - Pulse-one period is 7 bits of 32 ms, reset 20h, 0 acts as 1.
// - Pulse-two period is 7 bits of 32 ms, reset 14h, for selector 10.
// - Burst length is the 3-bit count plus one; pulse-two defaults to 100b.
// - Selector 11 period is its own 7-bit register, reset 5Dh.
// - Duty ramps between 4-bit lower and upper limits for every behaviour except direct, which holds the upper limit.
`timescale 1ns/1ps
module lbs_top
  import lbs_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic                 CLK_SYS_IN,
  input  wire logic                 NRST_IN,
  input  wire logic [7:0]           REG_ADDR_IN,
  input  wire logic                 REG_WR_IN,
  input  wire logic [7:0]           REG_WDATA_IN,
  input  wire logic [NUM_LED-1:0]   PIN_IS_INPUT_IN,
  input  wire logic [NUM_LED-1:0]   LINK_EN_IN,
  input  wire logic [NUM_LED-1:0]   POLARITY_IN,
  input  wire logic [NUM_LED-1:0]   DRIVE_ON_IN,
  input  wire logic [NUM_LED-1:0]   TOUCH_IN,
  input  wire logic                 POWER_INDICATOR_ENABLE_IN,
  input  wire logic                 SLEEP_IN,
  input  wire logic                 DEEP_SLEEP_ENABLE_IN,
  output logic      [7:0]           REG_RDATA_OUT,
  output logic      [NUM_LED-1:0]   LED_OUT,
  output logic      [NUM_LED-1:0]   LED_OE_OUT,
  output logic      [NUM_LED-1:0]   BUSY_OUT
);
  // ****************************************
  // register file
  // ****************************************
  logic [7:0]  beh_low_reg;
  logic [7:0]  beh_mid_reg;
  logic [7:0]  beh_high_reg;
  logic [6:0]  pulse_one_period_field_reg;
  logic [6:0]  pulse_two_period_field_reg;
  logic [6:0]  breathe_period_field_reg;
  logic [5:0]  cfg_reg;
  logic [7:0]  duty_p1_reg;
  logic [7:0]  duty_p2_reg;
  logic [7:0]  duty_br_reg;
  logic [7:0]  duty_dr_reg;
  logic [7:0]  rdata_next;
  logic [16:0] tick_cnt_reg;
  logic        tick_reg;
  logic [3:0]  pwm_reg;

  // write strobes per register
  wire wr_low  = REG_WR_IN && REG_ADDR_IN == OFS_BEH_LOW;
  wire wr_mid  = REG_WR_IN && REG_ADDR_IN == OFS_BEH_MID;
  wire wr_high = REG_WR_IN && REG_ADDR_IN == OFS_BEH_HIGH;
  wire wr_p1   = REG_WR_IN && REG_ADDR_IN == OFS_PULSE_ONE_PERIOD_FIELD;
  wire wr_p2   = REG_WR_IN && REG_ADDR_IN == OFS_PULSE_TWO_PERIOD_FIELD;
  wire wr_br   = REG_WR_IN && REG_ADDR_IN == OFS_BREATHE_PERIOD_FIELD;
  wire wr_cfg  = REG_WR_IN && REG_ADDR_IN == OFS_PULSE_CFG;
  wire wr_dp1  = REG_WR_IN && REG_ADDR_IN == OFS_DUTY_P1;
  wire wr_dp2  = REG_WR_IN && REG_ADDR_IN == OFS_DUTY_P2;
  wire wr_dbr  = REG_WR_IN && REG_ADDR_IN == OFS_DUTY_BR;
  wire wr_ddr  = REG_WR_IN && REG_ADDR_IN == OFS_DUTY_DR;

  // behaviour selector registers
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      beh_low_reg  <= RST_BEH;
      beh_mid_reg  <= RST_BEH;
      beh_high_reg <= RST_BEH;
    end else begin
      if (wr_low) beh_low_reg <= REG_WDATA_IN;
      if (wr_mid) beh_mid_reg <= REG_WDATA_IN;
      if (wr_high) beh_high_reg <= REG_WDATA_IN;
    end
  end

  // period registers, bit 7 is not stored
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pulse_one_period_field_reg <= RST_PULSE_ONE_PERIOD_FIELD;
      pulse_two_period_field_reg <= RST_PULSE_TWO_PERIOD_FIELD;
      breathe_period_field_reg <= RST_BREATHE_PERIOD_FIELD;
    end else begin
      if (wr_p1) pulse_one_period_field_reg <= REG_WDATA_IN[6:0];
      if (wr_p2) pulse_two_period_field_reg <= REG_WDATA_IN[6:0];
      if (wr_br) breathe_period_field_reg <= REG_WDATA_IN[6:0];
    end
  end

  // burst counts and duty limits
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cfg_reg     <= RST_PULSE_CFG;
      duty_p1_reg <= RST_DUTY;
      duty_p2_reg <= RST_DUTY;
      duty_br_reg <= RST_DUTY;
      duty_dr_reg <= RST_DUTY;
    end else begin
      if (wr_cfg) cfg_reg <= REG_WDATA_IN[5:0];
      if (wr_dp1) duty_p1_reg <= REG_WDATA_IN;
      if (wr_dp2) duty_p2_reg <= REG_WDATA_IN;
      if (wr_dbr) duty_br_reg <= REG_WDATA_IN;
      if (wr_ddr) duty_dr_reg <= REG_WDATA_IN;
    end
  end

  // ****************************************
  // read path, unmapped reads give zero
  // ****************************************
  assign rdata_next =
    (REG_ADDR_IN == OFS_BEH_LOW)   ? beh_low_reg :
    (REG_ADDR_IN == OFS_BEH_MID)   ? beh_mid_reg :
    (REG_ADDR_IN == OFS_BEH_HIGH)  ? beh_high_reg :
    (REG_ADDR_IN == OFS_PULSE_ONE_PERIOD_FIELD)    ? {1'b0, pulse_one_period_field_reg} :
    (REG_ADDR_IN == OFS_PULSE_TWO_PERIOD_FIELD)    ? {1'b0, pulse_two_period_field_reg} :
    (REG_ADDR_IN == OFS_BREATHE_PERIOD_FIELD)    ? {1'b0, breathe_period_field_reg} :
    (REG_ADDR_IN == OFS_PULSE_CFG) ? {2'h0, cfg_reg} :
    (REG_ADDR_IN == OFS_DUTY_P1)   ? duty_p1_reg :
    (REG_ADDR_IN == OFS_DUTY_P2)   ? duty_p2_reg :
    (REG_ADDR_IN == OFS_DUTY_BR)   ? duty_br_reg :
    (REG_ADDR_IN == OFS_DUTY_DR)   ? duty_dr_reg : 8'h00;

  // read data is registered
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) REG_RDATA_OUT <= 8'h00;
    else REG_RDATA_OUT <= rdata_next;
  end

  // ****************************************
  // shared ms tick and pwm frame counter
  // ****************************************
  wire tick_wrap = tick_cnt_reg == 17'(TICK_CYCLES_P - 1);

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tick_cnt_reg <= 17'h00000;
      tick_reg     <= 1'b0;
      pwm_reg      <= 4'h0;
    end else begin
      tick_cnt_reg <= tick_wrap ? 17'h00000 : tick_cnt_reg + 17'h00001;
      tick_reg     <= tick_wrap;
      pwm_reg      <= pwm_reg + 4'h1;
    end
  end

  // ****************************************
  // selector routing
  // ****************************************
  // output eleven takes the sleep selector only while asleep with indicator on
  wire        asleep  = SLEEP_IN || DEEP_SLEEP_ENABLE_IN;
  wire        use_alt = POWER_INDICATOR_ENABLE_IN && asleep;
  wire [1:0]  sel11   = use_alt ? beh_high_reg[ALT_LSB +: 2]
                                : beh_high_reg[AWAKE_LSB +: 2];
  wire [21:0] sel_w   = {sel11, beh_high_reg[3:0], beh_mid_reg, beh_low_reg};
  wire [2:0]  cnt1    = cfg_reg[CNT1_LSB +: 3];
  wire [2:0]  cnt2    = cfg_reg[CNT2_LSB +: 3];

  // ****************************************
  // one sequencer per led output
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < NUM_LED; i++) begin : g_led
      wire [1:0] sel = sel_w[2*i +: 2];
      // period, count and duty follow the selected behaviour
      wire [6:0] per = (sel == SEL_PULSE1) ? pulse_one_period_field_reg :
                       (sel == SEL_HOLD)   ? pulse_two_period_field_reg : breathe_period_field_reg;
      wire [2:0] cnt = (sel == SEL_PULSE1) ? cnt1 : cnt2;
      wire [7:0] dty = (sel == SEL_PULSE1) ? duty_p1_reg :
                       (sel == SEL_HOLD)   ? duty_p2_reg : duty_br_reg;
      lbs_channel lbs_channel_inst (
        .clk_in      (CLK_SYS_IN),
        .nrst_in     (NRST_IN),
        .tick_in     (tick_reg),
        .pwm_in      (pwm_reg),
        .sel_in      (sel),
        .linked_in   (LINK_EN_IN[i]),
        .is_input_in (PIN_IS_INPUT_IN[i]),
        .pol_in      (POLARITY_IN[i]),
        .drive_in    (DRIVE_ON_IN[i]),
        .press_in    (TOUCH_IN[i]),
        .period_in   (per),
        .count_in    (cnt),
        .duty_in     (dty),
        .duty_dr_in  (duty_dr_reg),
        .pin_out     (LED_OUT[i]),
        .oe_out      (LED_OE_OUT[i]),
        .busy_out    (BUSY_OUT[i])
      );
    end
  endgenerate

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);

  property p_wr_low;
    wr_low |=> sel_w[7:6] == $past(REG_WDATA_IN[7:6]) && sel_w[1:0] == $past(REG_WDATA_IN[1:0]);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("led four or one selector misplaced");

  property p_wr_mid;
    wr_mid |=> sel_w[15:14] == $past(REG_WDATA_IN[7:6]) && sel_w[9:8] == $past(REG_WDATA_IN[1:0]);
  endproperty
  a_wr_mid: assert property (p_wr_mid) else $error("led eight or five selector misplaced");

  property p_alt_sel;
    use_alt |-> sel_w[21:20] == beh_high_reg[7:6];
  endproperty
  a_alt_sel: assert property (p_alt_sel) else $error("led eleven not on sleep selector");

  property p_awake_sel;
    (POWER_INDICATOR_ENABLE_IN && !asleep) |-> sel_w[21:20] == beh_high_reg[5:4];
  endproperty
  a_awake_sel: assert property (p_awake_sel) else $error("led eleven not on awake selector");

  property p_input_ignored;
    PIN_IS_INPUT_IN[0] |=> !LED_OE_OUT[0] && !BUSY_OUT[0];
  endproperty
  a_input_ignored: assert property (p_input_ignored) else $error("input pin still driven");

  property p_idle_level;
    (!PIN_IS_INPUT_IN[0] && sel_w[1:0] == SEL_DIRECT && !DRIVE_ON_IN[0] && !TOUCH_IN[0])
      |=> LED_OUT[0] == !$past(POLARITY_IN[0]);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle pin at wrong level");

  property p_unlinked_pulse;
    (sel_w[1:0] == SEL_PULSE1 && !LINK_EN_IN[0]) |=> !BUSY_OUT[0];
  endproperty
  a_unlinked_pulse: assert property (p_unlinked_pulse) else $error("unlinked pulse ran");

  property p_pulse_start;
    (LINK_EN_IN[0] && sel_w[1:0] == SEL_PULSE1 && !PIN_IS_INPUT_IN[0] && !BUSY_OUT[0]
      && TOUCH_IN[0] && !$past(TOUCH_IN[0])) |=> BUSY_OUT[0];
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("press did not start burst");

  property p_hold_run;
    (LINK_EN_IN[0] && sel_w[1:0] == SEL_HOLD && TOUCH_IN[0] && !PIN_IS_INPUT_IN[0])
      |=> BUSY_OUT[0];
  endproperty
  a_hold_run: assert property (p_hold_run) else $error("held press not breathing");

  property p_breathe_unlinked;
    (!LINK_EN_IN[0] && sel_w[1:0] == SEL_BREATHE && DRIVE_ON_IN[0] && !PIN_IS_INPUT_IN[0])
      |=> BUSY_OUT[0];
  endproperty
  a_breathe_unlinked: assert property (p_breathe_unlinked) else $error("no breathe");

  property p_tick_single;
    tick_reg |=> !tick_reg;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick wider than a cycle");

  property p_period_msb;
    (REG_ADDR_IN == OFS_PULSE_ONE_PERIOD_FIELD || REG_ADDR_IN == OFS_PULSE_TWO_PERIOD_FIELD) |=> !REG_RDATA_OUT[7];
  endproperty
  a_period_msb: assert property (p_period_msb) else $error("period bit 7 not zero");

  // ****************************************
  // register storage and read-back, output eleven routing and tick wrap
  // ****************************************
  property p_wr_high;
    wr_high |=> sel_w[19:16] == $past(REG_WDATA_IN[3:0]);
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("led ten or nine selector misplaced");

  property p_wr_p1;
    wr_p1 |=> pulse_one_period_field_reg == $past(REG_WDATA_IN[6:0]);
  endproperty
  a_wr_p1: assert property (p_wr_p1) else $error("pulse one period not stored");

  property p_wr_p2;
    wr_p2 |=> pulse_two_period_field_reg == $past(REG_WDATA_IN[6:0]);
  endproperty
  a_wr_p2: assert property (p_wr_p2) else $error("pulse two period not stored");

  property p_wr_br;
    wr_br |=> breathe_period_field_reg == $past(REG_WDATA_IN[6:0]);
  endproperty
  a_wr_br: assert property (p_wr_br) else $error("breathe period not stored");

  property p_wr_cnt;
    wr_cfg |=> cnt2 == $past(REG_WDATA_IN[5:3]) && cnt1 == $past(REG_WDATA_IN[2:0]);
  endproperty
  a_wr_cnt: assert property (p_wr_cnt) else $error("burst counts misplaced");

  property p_rd_low;
    (REG_ADDR_IN == OFS_BEH_LOW) |=> REG_RDATA_OUT == $past(beh_low_reg);
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("selector read back wrong");

  property p_alt_off;
    !POWER_INDICATOR_ENABLE_IN |-> sel_w[21:20] == beh_high_reg[AWAKE_LSB +: 2];
  endproperty
  a_alt_off: assert property (p_alt_off) else $error("led eleven left awake selector");

  property p_tick_wrap;
    tick_wrap |=> tick_reg && tick_cnt_reg == 17'h00000;
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("tick not at counter wrap");

  // ****************************************
  // pin behaviour of output one, and covers of outputs one and eleven
  // ****************************************
  property p_oe_driven;
    !PIN_IS_INPUT_IN[0] |=> LED_OE_OUT[0];
  endproperty
  a_oe_driven: assert property (p_oe_driven) else $error("output pin not enabled");

  property p_direct_idle;
    sel_w[1:0] == SEL_DIRECT |=> !BUSY_OUT[0];
  endproperty
  a_direct_idle: assert property (p_direct_idle) else $error("direct output ran a sequence");

  property p_linked_direct;
    (LINK_EN_IN[0] && sel_w[1:0] == SEL_DIRECT && TOUCH_IN[0] && !PIN_IS_INPUT_IN[0]
      && !POLARITY_IN[0] && duty_dr_reg[7:4] == 4'hF) |=> !LED_OUT[0];
  endproperty
  a_linked_direct: assert property (p_linked_direct) else $error("press did not light led");

  c_burst: cover property (LINK_EN_IN[0] && sel_w[1:0] == SEL_PULSE1 && BUSY_OUT[0]);
  c_hold_release: cover property (BUSY_OUT[0] && sel_w[1:0] == SEL_HOLD && !TOUCH_IN[0]);
  c_sleep_alt: cover property (use_alt && BUSY_OUT[10]);
  c_unlinked_breathe: cover property (!LINK_EN_IN[0] && sel_w[1:0] == SEL_BREATHE && BUSY_OUT[0]);
  c_input_pin: cover property (PIN_IS_INPUT_IN[0] && !LED_OE_OUT[0]);
endmodule

//--- sim/lbs_far_side.sv
// far-side model: touch sensors that press and release, leds that glow
`timescale 1ns/1ps
module lbs_far_side
  import lbs_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic [NUM_LED-1:0] led_in,
  input  wire logic [NUM_LED-1:0] oe_in,
  output logic      [NUM_LED-1:0] touch_out
);
  // ****************************************
  // sensors and led loads
  // ****************************************
  int lit_count [NUM_LED];

  initial begin
    touch_out = '0;
  end

  // a press or release lands just after an edge and then holds
  task automatic touch(input int idx, input logic lvl);
    @(posedge clk_in);
    #1;
    touch_out[idx] = lvl;
  endtask

  task automatic clear();
    foreach (lit_count[i]) lit_count[i] = 0;
  endtask

  // a low-side driven led glows while its pin is driven low
  always @(posedge clk_in) begin
    foreach (lit_count[i]) begin
      if (oe_in[i] === 1'b1 && led_in[i] === 1'b0) lit_count[i]++;
    end
  end
endmodule

//--- sim/lbs_test.sv
// self-checking bench of the led behaviour sequencer
`timescale 1ns/1ps
module lbs_test
  import lbs_pkg::*;
;
  localparam int TICK   = 4;
  localparam int BREATH = STEP_MS * TICK; // cycles of one breath at period 1
  logic               clk;
  logic               nrst;
  logic [7:0]         addr;
  logic               wr_en;
  logic [7:0]         wdata;
  logic [NUM_LED-1:0] is_in, link, pol, drv, touch, led, oe, busy;
  logic               pwr, slp, dslp;
  logic [7:0]         rdata;
  int                 n_errors  = 0;
  int                 cmp_count = 0;
  int                 per_t [3] = '{0, 2, 1};
  int                 cnt_t [3] = '{4, 0, 7};
  int                 e;

  lbs_top #(.TICK_CYCLES_P(TICK)) lbs_top_inst (
    .CLK_SYS_IN(clk), .NRST_IN(nrst), .REG_ADDR_IN(addr), .REG_WR_IN(wr_en),
    .REG_WDATA_IN(wdata), .PIN_IS_INPUT_IN(is_in), .LINK_EN_IN(link),
    .POLARITY_IN(pol), .DRIVE_ON_IN(drv), .TOUCH_IN(touch),
    .POWER_INDICATOR_ENABLE_IN(pwr), .SLEEP_IN(slp), .DEEP_SLEEP_ENABLE_IN(dslp),
    .REG_RDATA_OUT(rdata), .LED_OUT(led), .LED_OE_OUT(oe), .BUSY_OUT(busy));
  lbs_far_side lbs_far_side_inst (.clk_in(clk), .led_in(led), .oe_in(oe), .touch_out(touch));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    cyc(1);
    addr = a;
    cyc(1);
    chk(what, 16'(rdata), 16'(exp));
  endtask

  // waits for busy, then counts the cycles it stays high
  task automatic burst(input int idx, input int exp, input string what);
    int len;
    len = 0;
    for (int i = 0; i < 20 && busy[idx] !== 1'b1; i++) cyc(1);
    while (busy[idx] === 1'b1 && len < 3000) begin
      cyc(1);
      len++;
    end
    chk(what, 16'(len > exp - 8 && len < exp + 8), 16'h1);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    nrst  = 1'b0;
    addr  = 8'h00;
    wr_en = 1'b0;
    wdata = 8'h00;
    {is_in, link, pol, drv} = '0;
    {pwr, slp, dslp} = 3'h0;
    cyc(10);
    chk("led in reset", 16'(led), 16'h07FF);
    nrst = 1'b1;
    rd(8'h81, 8'h00, "beh low");
    rd(8'h82, 8'h00, "beh mid");
    rd(8'h83, 8'h00, "beh high");
    rd(8'h84, 8'h20, "p1 period");
    rd(8'h85, 8'h14, "p2 period");
    rd(8'h86, 8'h5D, "br period");
    rd(8'h88, 8'h24, "pulse cfg");
    rd(8'h92, 8'hF0, "duty br");
    wr(8'h84, 8'hFF);
    rd(8'h84, 8'h7F, "p1 period 7 bits");
    wr(8'h87, 8'hAA);
    rd(8'h87, 8'h00, "unmapped");
    $display("test registers done");
    chk("idle pins", 16'(led), 16'h07FF);
    chk("oe", 16'(oe), 16'h07FF);
    pol[1] = 1'b1;
    cyc(3);
    chk("idle non-inverted", 16'(led[1]), 16'h0);
    pol[1] = 1'b0;
    drv[0] = 1'b1;
    cyc(4);
    lbs_far_side_inst.clear();
    cyc(32);
    chk("direct on", 16'(lbs_far_side_inst.lit_count[0]), 16'd32);
    drv[0] = 1'b0;
    $display("test polarity and direct done");
    wr(8'h86, 8'h01);
    // unlinked outputs run only while their control bit is on
    drv[3:0] = 4'hD;
    wr(8'h81, 8'hE7);
    cyc(3);
    chk("unlinked busy", 16'(busy[3:0]), 16'hD);
    lbs_far_side_inst.clear();
    cyc(2 * BREATH);
    e = lbs_far_side_inst.lit_count[3];
    chk("breathe ramp", 16'(e > BREATH / 2 && e < 3 * BREATH / 2), 16'h1);
    is_in = 11'h009;
    cyc(3);
    chk("input pin busy", 16'(busy[3:0]), 16'h4);
    chk("input pin oe", 16'(oe[3:0]), 16'h6);
    is_in = '0;
    wr(8'h81, 8'h00);
    drv = '0;
    $display("test unlinked breathe done");
    link[0] = 1'b1;
    lbs_far_side_inst.touch(0, 1'b1);
    cyc(4);
    lbs_far_side_inst.clear();
    cyc(16);
    chk("linked press", 16'(lbs_far_side_inst.lit_count[0]), 16'd16);
    lbs_far_side_inst.touch(0, 1'b0);
    cyc(3);
    chk("linked release", 16'(led[0]), 16'h1);
    wr(8'h81, 8'h01);
    foreach (per_t[k]) begin
      wr(8'h84, 8'(per_t[k]));
      wr(8'h88, 8'h20 | 8'(cnt_t[k]));
      e = (per_t[k] < 1 ? 1 : per_t[k]) * BREATH * (cnt_t[k] + 1);
      lbs_far_side_inst.touch(0, 1'b1);
      fork
        burst(0, e, "pulse one burst");
        begin
          cyc(40);
          lbs_far_side_inst.touch(0, 1'b0);
        end
      join
    end
    $display("test pulse one done");
    wr(8'h82, 8'h02);
    wr(8'h85, 8'h01);
    wr(8'h81, 8'h02);
    link[4] = 1'b1;
    lbs_far_side_inst.touch(0, 1'b1);
    lbs_far_side_inst.touch(4, 1'b1);
    // release lands mid-breath: that partial breath is the first of five
    cyc(319);
    chk("hold breathing", 16'(busy[4]), 16'h1);
    chk("hold breathing out one", 16'(busy[0]), 16'h1);
    lbs_far_side_inst.touch(4, 1'b0);
    burst(4, 4 * BREATH + BREATH / 2, "release burst");
    lbs_far_side_inst.touch(0, 1'b0);
    $display("test hold done");
    drv[10:8] = 3'h7;
    wr(8'h83, 8'hCC);
    pwr = 1'b1;
    slp = 1'b1;
    cyc(3);
    chk("out 9 10", 16'(busy[9:8]), 16'h2);
    chk("sleep sel", 16'(busy[10]), 16'h1);
    slp = 1'b0;
    cyc(3);
    chk("awake sel", 16'(busy[10]), 16'h0);
    dslp = 1'b1;
    cyc(3);
    chk("deep sleep sel", 16'(busy[10]), 16'h1);
    $display("test output eleven done");
    end_sim();
  end

  // cuts a hang short
  initial begin
    #(8 * 20000);
    n_errors++;
    end_sim();
  end
endmodule
